// ---- rtl/pie_map.svh ----
// register offsets, field positions, masks and reset values of the enable block
`ifndef PIE_MAP_SVH
`define PIE_MAP_SVH

// ****************************************************************
// register byte offsets on the register bus
// ****************************************************************
`define PIE_OFF_EN_A 8'h00
`define PIE_OFF_EN_B 8'h04
`define PIE_OFF_FLAG_A 8'h08
`define PIE_OFF_FLAG_B 8'h0c
`define PIE_OFF_CLR_A 8'h10
`define PIE_OFF_CLR_B 8'h14
`define PIE_OFF_CTRL 8'h18

// ****************************************************************
// implemented bits, reset values and field positions
// ****************************************************************
`define PIE_EN_A_MASK 8'h7f
`define PIE_EN_B_MASK 8'hf0
`define PIE_CTRL_MASK 8'hc0
`define PIE_BYTE_RESET 8'h00
`define PIE_CTRL_GLOBAL_BIT 7
`define PIE_CTRL_GROUP_BIT 6
`define PIE_ALIGN_ZERO 2'h0
`define PIE_WORD_ZERO 32'h0000_0000
`define PIE_PAD_ZERO 24'h00_0000

`endif

// ---- rtl/pie_pkg.sv ----
// types shared by the enable block and its bench
package pie_pkg;

	// apb request from the master, one bundle
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} pie_apb_req_t;

	// first enable register layout, bit 7 down to bit 0
	typedef struct packed {
		logic unused7;
		logic adc_done_irq_en;
		logic serial_rx_irq_en;
		logic serial_tx_irq_en;
		logic sync_serial_irq_en;
		logic capture_compare_irq_en;
		logic period_match_irq_en;
		logic counter_overflow_irq_en;
	} pie_en_a_t;

	// second enable register layout, bit 7 down to bit 0
	typedef struct packed {
		logic osc_fail_irq_en;
		logic comparator_b_irq_en;
		logic comparator_a_irq_en;
		logic nvm_write_done_irq_en;
		logic [3:0] unused3_0;
	} pie_en_b_t;

endpackage

// ---- rtl/pie_flag_bank.sv ----
// bank of sticky event flags, set wins over clear
`timescale 1ns/10ps

module pie_flag_bank #(
	parameter int W = 8,
	parameter logic [7:0] MASK = 8'hff
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic [W-1:0] set_in,
	input wire logic [W-1:0] clr_in,
	output logic [W-1:0] flags_out
);

	logic [W-1:0] flags_reg; // held flags
	logic [W-1:0] flags_next; // next flags
	logic [W-1:0] mask_w; // implemented bits

	assign mask_w = MASK[W-1:0];

	// ****************************************************************
	// next value: clear first, then the event sets again
	// ****************************************************************
	always_comb begin
		flags_next = ((flags_reg & ~clr_in) | set_in) & mask_w;
	end

	// register only
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_out = flags_reg;

endmodule

// ---- rtl/pie_core.sv ----
// peripheral interrupt enable block with apb registers and one irq line
`timescale 1ns/10ps
`include "pie_map.svh"

module pie_core (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire pie_pkg::pie_apb_req_t apb_req_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [7:0] evt_a_in,
	input wire logic [7:0] evt_b_in,
	output logic irq_out
);
	import pie_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	pie_en_a_t en_a_reg; // first enable register
	pie_en_a_t en_a_next;
	pie_en_b_t en_b_reg; // second enable register
	pie_en_b_t en_b_next;
	logic [7:0] ctrl_reg; // global and group enables
	logic [7:0] ctrl_next;
	logic pready_reg; // access phase answer
	logic pready_next;
	logic [31:0] prdata_reg; // read data
	logic [31:0] prdata_next;
	logic pslverr_reg; // unmapped address answer
	logic pslverr_next;
	logic irq_reg; // interrupt line
	logic irq_next;
	logic [7:0] flags_a; // first flag bank
	logic [7:0] flags_b; // second flag bank
	logic [7:0] clr_a; // write-one-to-clear strobes
	logic [7:0] clr_b;
	logic [7:0] hit_a; // flag and enable per source
	logic [7:0] hit_b;
	logic acc_phase; // psel and penable
	logic acc_done; // transfer completes at this edge
	logic wr_done; // write completes at this edge
	logic mapped; // address decodes to a register
	logic pend_any; // any unmasked source

	// ****************************************************************
	// helper functions
	// ****************************************************************
	// address match on an aligned word
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
		addr_is = (addr == off);
	endfunction

	// widen one register byte to the bus word
	function automatic logic [31:0] word_of(input logic [7:0] b);
		word_of = {`PIE_PAD_ZERO, b};
	endfunction

	// ****************************************************************
	// bus phase decode
	// ****************************************************************
	always_comb begin
		acc_phase = apb_req_in.psel & apb_req_in.penable;
		acc_done = acc_phase & pready_reg;
		wr_done = acc_done & apb_req_in.pwrite;
		mapped = (apb_req_in.paddr[1:0] == `PIE_ALIGN_ZERO) &&
			(addr_is(apb_req_in.paddr, `PIE_OFF_EN_A) ||
			addr_is(apb_req_in.paddr, `PIE_OFF_EN_B) ||
			addr_is(apb_req_in.paddr, `PIE_OFF_FLAG_A) ||
			addr_is(apb_req_in.paddr, `PIE_OFF_FLAG_B) ||
			addr_is(apb_req_in.paddr, `PIE_OFF_CLR_A) ||
			addr_is(apb_req_in.paddr, `PIE_OFF_CLR_B) ||
			addr_is(apb_req_in.paddr, `PIE_OFF_CTRL));
	end

	// ****************************************************************
	// bus answer: one wait cycle, data and error with pready
	// ****************************************************************
	always_comb begin
		pready_next = acc_phase & ~pready_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		if (acc_phase && !pready_reg) begin
			// capture the answer in the first access cycle
			pslverr_next = ~mapped;
			if (apb_req_in.pwrite || !mapped) begin
				prdata_next = `PIE_WORD_ZERO;
			end else if (addr_is(apb_req_in.paddr, `PIE_OFF_EN_A)) begin
				prdata_next = word_of(en_a_reg);
			end else if (addr_is(apb_req_in.paddr, `PIE_OFF_EN_B)) begin
				prdata_next = word_of(en_b_reg);
			end else if (addr_is(apb_req_in.paddr, `PIE_OFF_FLAG_A)) begin
				prdata_next = word_of(flags_a);
			end else if (addr_is(apb_req_in.paddr, `PIE_OFF_FLAG_B)) begin
				prdata_next = word_of(flags_b);
			end else if (addr_is(apb_req_in.paddr, `PIE_OFF_CTRL)) begin
				prdata_next = word_of(ctrl_reg);
			end else begin
				// clear registers are write-only and read zero
				prdata_next = `PIE_WORD_ZERO;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pready_reg <= 1'b0;
			prdata_reg <= `PIE_WORD_ZERO;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ****************************************************************
	// enable and control registers
	// ****************************************************************
	always_comb begin
		en_a_next = en_a_reg;
		en_b_next = en_b_reg;
		ctrl_next = ctrl_reg;
		clr_a = `PIE_BYTE_RESET;
		clr_b = `PIE_BYTE_RESET;
		if (wr_done) begin
			// unimplemented bits are masked off on every write
			if (addr_is(apb_req_in.paddr, `PIE_OFF_EN_A)) begin
				en_a_next = apb_req_in.pwdata[7:0] & `PIE_EN_A_MASK;
			end
			if (addr_is(apb_req_in.paddr, `PIE_OFF_EN_B)) begin
				en_b_next = apb_req_in.pwdata[7:0] & `PIE_EN_B_MASK;
			end
			if (addr_is(apb_req_in.paddr, `PIE_OFF_CTRL)) begin
				ctrl_next = apb_req_in.pwdata[7:0] & `PIE_CTRL_MASK;
			end
			// only software clears a flag
			if (addr_is(apb_req_in.paddr, `PIE_OFF_CLR_A)) begin
				clr_a = apb_req_in.pwdata[7:0];
			end
			if (addr_is(apb_req_in.paddr, `PIE_OFF_CLR_B)) begin
				clr_b = apb_req_in.pwdata[7:0];
			end
		end
	end

	// enables start masked after reset
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			en_a_reg <= `PIE_BYTE_RESET;
			en_b_reg <= `PIE_BYTE_RESET;
			ctrl_reg <= `PIE_BYTE_RESET;
		end else begin
			en_a_reg <= en_a_next;
			en_b_reg <= en_b_next;
			ctrl_reg <= ctrl_next;
		end
	end

	// ****************************************************************
	// sticky event flags, set regardless of any enable
	// ****************************************************************
	pie_flag_bank #(
		.W(8),
		.MASK(`PIE_EN_A_MASK)
	) u_flags_a (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(evt_a_in),
		.clr_in(clr_a),
		.flags_out(flags_a)
	);

	pie_flag_bank #(
		.W(8),
		.MASK(`PIE_EN_B_MASK)
	) u_flags_b (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.set_in(evt_b_in),
		.clr_in(clr_b),
		.flags_out(flags_b)
	);

	// ****************************************************************
	// per-source gating and the interrupt line
	// ****************************************************************
	always_comb begin
		hit_a = `PIE_BYTE_RESET;
		hit_b = `PIE_BYTE_RESET;
		hit_a[6] = flags_a[6] & en_a_reg.adc_done_irq_en;
		hit_a[5] = flags_a[5] & en_a_reg.serial_rx_irq_en;
		hit_a[4] = flags_a[4] & en_a_reg.serial_tx_irq_en;
		hit_a[3] = flags_a[3] & en_a_reg.sync_serial_irq_en;
		hit_a[2] = flags_a[2] & en_a_reg.capture_compare_irq_en;
		hit_a[1] = flags_a[1] & en_a_reg.period_match_irq_en;
		hit_a[0] = flags_a[0] & en_a_reg.counter_overflow_irq_en;
		hit_b[7] = flags_b[7] & en_b_reg.osc_fail_irq_en;
		hit_b[6] = flags_b[6] & en_b_reg.comparator_b_irq_en;
		hit_b[5] = flags_b[5] & en_b_reg.comparator_a_irq_en;
		hit_b[4] = flags_b[4] & en_b_reg.nvm_write_done_irq_en;
		// an old flag fires one edge after it is enabled, with no new event
		pend_any = (|hit_a) | (|hit_b);
		irq_next = pend_any & ctrl_reg[`PIE_CTRL_GROUP_BIT]
			& ctrl_reg[`PIE_CTRL_GLOBAL_BIT];
	end

	// register only
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign irq_out = irq_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	// unimplemented bits never hold a one
	a_en_a_top: assert property ((en_a_reg & ~`PIE_EN_A_MASK) == 8'h00)
		else $error("first enable top bit set");

	a_en_b_low: assert property ((en_b_reg & ~`PIE_EN_B_MASK) == 8'h00)
		else $error("second enable low bits set");

	// a write to an enable register lands on the next edge
	a_en_write_lands: assert property (
		(wr_done && addr_is(apb_req_in.paddr, `PIE_OFF_EN_A))
		|=> en_a_reg == ($past(apb_req_in.pwdata[7:0]) & `PIE_EN_A_MASK))
		else $error("first enable write lost");

	// the line rises only with the group enable
	a_irq_group_gate: assert property (
		irq_out |-> $past(ctrl_reg[`PIE_CTRL_GROUP_BIT]))
		else $error("irq without group enable");

	// the line rises only with the global enable
	a_irq_global_gate: assert property (
		irq_out |-> $past(ctrl_reg[`PIE_CTRL_GLOBAL_BIT]))
		else $error("irq without global enable");

	// an event shows in the flag on the next edge
	a_flag_on_event: assert property (
		(|(evt_b_in & `PIE_EN_B_MASK))
		|=> ((flags_b & $past(evt_b_in & `PIE_EN_B_MASK)) == $past(evt_b_in & `PIE_EN_B_MASK)))
		else $error("event flag not set");

	// a flag drops only under a clear write
	a_flag_sticky: assert property (
		##1 ((flags_a & $past(flags_a) & ~$past(clr_a)) == ($past(flags_a) & ~$past(clr_a))))
		else $error("flag dropped without clear");

	// the line follows the or of gated sources one edge later
	a_irq_or_term: assert property (
		##1 irq_out == $past(((|(flags_a & en_a_reg)) | (|(flags_b & en_b_reg)))
		& ctrl_reg[`PIE_CTRL_GROUP_BIT] & ctrl_reg[`PIE_CTRL_GLOBAL_BIT]))
		else $error("irq not the gated or");

	// leaving reset both enable registers are clear and the line is low
	a_reset_masked: assert property (
		$rose(rst_b_in) |-> (en_a_reg == 8'h00 && en_b_reg == 8'h00 && !irq_out))
		else $error("enables not clear after reset");

	// a transfer answers one cycle into the access phase
	a_bus_answer: assert property (
		(acc_phase && !pready_reg) |=> pready_reg)
		else $error("late bus answer");

	// main scenarios
	c_irq_rise: cover property ($rose(irq_out));
	c_set_and_clear: cover property (|(evt_a_in & clr_a & `PIE_EN_A_MASK));
	c_unmapped: cover property (pslverr_out && pready_out);
	c_en_write: cover property (wr_done && addr_is(apb_req_in.paddr, `PIE_OFF_EN_B));

endmodule

// ---- tb/tb_peripheral_interrupt_enable.sv ----
// self-checking bench for the peripheral interrupt enable block
`timescale 1ns/10ps
`include "pie_map.svh"

module tb_peripheral_interrupt_enable;
	import pie_pkg::*;

	// ****************************************************************
	// signals
	// ****************************************************************
	logic core_clk_in; // 25 MHz core clock
	logic rst_b_in; // synchronous reset, active low
	pie_apb_req_t req; // apb request bundle
	logic [31:0] prdata; // read data
	logic pready; // transfer done
	logic pslverr; // transfer refused
	logic irq; // interrupt level
	logic [7:0] evt_a; // first bank events
	logic [7:0] evt_b; // second bank events
	int fail_count; // mismatches
	int check_count; // comparisons
	int cyc = 0; // cycles since start, counted only by the hang guard
	logic [31:0] rd; // data of the last transfer
	logic err; // error of the last transfer
	logic [7:0] ma; // one-hot enable, first bank
	logic [7:0] mb; // one-hot enable, second bank

	pie_core dut (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.apb_req_in(req),
		.prdata_out(prdata),
		.pready_out(pready),
		.pslverr_out(pslverr),
		.evt_a_in(evt_a),
		.evt_b_in(evt_b),
		.irq_out(irq)
	);

	// ****************************************************************
	// clock and hang guard
	// ****************************************************************
	// free-running clock, 40 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end

	// run is a few hundred cycles, so a stall ends here
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			finish_test();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	// counts, then verdict
	task automatic finish_test();
		$display("counts: %0d checks, %0d mismatches", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// compare seen against expected
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
			fail_count++;
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge core_clk_in);
		req.penable <= 1'b1;
		@(posedge core_clk_in);
		while (pready !== 1'b1) @(posedge core_clk_in);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// register read and compare
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(n, rd, e);
	endtask

	// one-cycle event pulse on both banks
	task automatic pulse(input logic [7:0] a, input logic [7:0] b);
		@(posedge core_clk_in);
		evt_a <= a;
		evt_b <= b;
		@(posedge core_clk_in);
		evt_a <= 8'h00;
		evt_b <= 8'h00;
	endtask

	// irq after its two-edge latency has passed
	task automatic irqchk(input logic e);
		repeat (2) @(posedge core_clk_in);
		#1;
		check("irq", {31'h0, irq}, {31'h0, e});
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		req = '0;
		evt_a = 8'h00;
		evt_b = 8'h00;
		rst_b_in = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (4) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		// both enable registers, the first flag register and the control register start cleared
		rdc("en_a reset", `PIE_OFF_EN_A, 32'h0);
		rdc("en_b reset", `PIE_OFF_EN_B, 32'h0);
		rdc("flag_a reset", `PIE_OFF_FLAG_A, 32'h0);
		rdc("ctrl reset", `PIE_OFF_CTRL, 32'h0);
		$display("test reset done");
		// unimplemented enable bits
		wr(`PIE_OFF_EN_A, 32'hff);
		rdc("en_a mask", `PIE_OFF_EN_A, 32'h7f);
		wr(`PIE_OFF_EN_B, 32'hff);
		rdc("en_b mask", `PIE_OFF_EN_B, 32'hf0);
		wr(`PIE_OFF_EN_A, 32'h00);
		wr(`PIE_OFF_EN_B, 32'h00);
		// misaligned and unmapped accesses are refused
		wr(8'h01, 32'h55);
		check("misaligned err", {31'h0, err}, 32'h1);
		rdc("en_a kept", `PIE_OFF_EN_A, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		rdc("clear reads zero", `PIE_OFF_CLR_A, 32'h0);
		$display("test access done");
		// flags set with every enable off, irq stays low
		pulse(8'hff, 8'hff);
		irqchk(1'b0);
		rdc("flag_a all", `PIE_OFF_FLAG_A, 32'h7f);
		rdc("flag_b all", `PIE_OFF_FLAG_B, 32'hf0);
		// a write to a flag register is ignored without error
		wr(`PIE_OFF_FLAG_A, 32'h00);
		check("flag write err", {31'h0, err}, 32'h0);
		rdc("flag_a write ignored", `PIE_OFF_FLAG_A, 32'h7f);
		// event held across the clear write: the set wins
		evt_a <= 8'h01;
		wr(`PIE_OFF_CLR_A, 32'h7f);
		evt_a <= 8'h00;
		rdc("set wins over clear", `PIE_OFF_FLAG_A, 32'h01);
		$display("test flags done");
		// each source gated by its own enable bit only
		wr(`PIE_OFF_CTRL, 32'hc0);
		for (int i = 0; i < 11; i++) begin
			ma = (i < 7) ? (8'h01 << i) : 8'h00;
			mb = (i < 7) ? 8'h00 : (8'h10 << (i - 7));
			wr(`PIE_OFF_CLR_A, 32'hff);
			wr(`PIE_OFF_CLR_B, 32'hff);
			wr(`PIE_OFF_EN_A, {24'h0, ma});
			wr(`PIE_OFF_EN_B, {24'h0, mb});
			irqchk(1'b0);
			pulse(~ma, ~mb);
			irqchk(1'b0);
			pulse(ma, mb);
			irqchk(1'b1);
		end
		$display("test sources done");
		// group and global enables, sticky flag
		wr(`PIE_OFF_CTRL, 32'h80);
		irqchk(1'b0);
		wr(`PIE_OFF_CTRL, 32'h40);
		irqchk(1'b0);
		wr(`PIE_OFF_CTRL, 32'hc0);
		irqchk(1'b1);
		wr(`PIE_OFF_CLR_B, 32'h80);
		irqchk(1'b0);
		rdc("flag_b after clear", `PIE_OFF_FLAG_B, 32'h70);
		$display("test gating done");
		finish_test();
	end

endmodule
